// ==== logic/lfcs_pkg.sv ====
// Constants for the legacy floating-point control and status register bank
`default_nettype none
package lfcs_pkg;
    localparam logic [63:0] LFCS_CTL_STORE_MASK = 64'h0000_FF80_0000_1FFF;
    localparam logic [63:0] LFCS_CTL_RESV_MASK  = 64'hFFFF_0040_FFFF_E000;
    localparam logic [63:0] LFCS_STS_STORE_MASK = 64'h0000_003F_5555_7FFF;
    localparam logic [63:0] LFCS_STS_RESV_MASK  = 64'hFFFF_0040_0000_0000;
    localparam logic [63:0] LFCS_CTL_RESET      = 64'h0000_0000_0000_0000;
    localparam logic [63:0] LFCS_STS_RESET      = 64'h0000_0000_0000_0000;
    localparam int LFCS_EXC_LSB   = 0;
    localparam int LFCS_EXC_W     = 6;
    localparam int LFCS_SF_BIT    = 6;
    localparam int LFCS_ES_BIT    = 7;
    localparam int LFCS_C0_BIT    = 8;
    localparam int LFCS_C1_BIT    = 9;
    localparam int LFCS_C2_BIT    = 10;
    localparam int LFCS_TOP_LSB   = 11;
    localparam int LFCS_TOP_W     = 3;
    localparam int LFCS_C3_BIT    = 14;
    localparam int LFCS_BUSY_BIT  = 15;
    localparam int LFCS_TAG_LSB   = 16;
    localparam int LFCS_NREG      = 8;
    localparam int LFCS_VEXC_LSB  = 32;
    localparam int LFCS_MASK_LSB  = 0;
    localparam logic       LFCS_SEL_CTL = 1'b0;
    localparam logic       LFCS_SEL_STS = 1'b1;
    localparam logic [1:0] LFCS_TAG_VALID   = 2'h0;
    localparam logic [1:0] LFCS_TAG_ZERO    = 2'h1;
    localparam logic [1:0] LFCS_TAG_SPECIAL = 2'h2;
    localparam logic [1:0] LFCS_TAG_EMPTY   = 2'h3;
    // Wide-exponent codes whose biased value fits the 15-bit extended range
    localparam logic [16:0] LFCS_EXP_LO   = 17'h0C000;
    localparam logic [16:0] LFCS_EXP_HI   = 17'h13FFE;
    localparam logic [16:0] LFCS_EXP_ZERO = 17'h00000;
    localparam logic [16:0] LFCS_EXP_MAX  = 17'h1FFFF;
    localparam logic [63:0] LFCS_SNAN_SIG = 64'hA000_0000_0000_0000;
endpackage
`default_nettype wire

// ==== logic/lfcs_regs.sv ====
// Legacy floating-point control/status register bank with operand checks
`default_nettype none
module lfcs_regs
    import lfcs_pkg::*;
#(
    parameter bit          NAT_FAULTS  = 1'b0,
    parameter logic [16:0] SGL_DEN_EXP = 17'h00001,
    parameter logic [16:0] DBL_DEN_EXP = 17'h00002
) (
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    input  wire logic        ar_wr_i,
    input  wire logic        ar_rd_i,
    input  wire logic        ar_sel_i,
    input  wire logic [63:0] ar_wdata_i,
    output logic      [63:0] ar_rdata_o,
    output logic             ar_rvalid_o,
    output logic             ar_resv_fault_o,
    input  wire logic        leg_upd_i,
    input  wire logic [5:0]  leg_exc_i,
    input  wire logic        leg_sf_i,
    input  wire logic [3:0]  leg_cc_i,
    input  wire logic [2:0]  leg_top_i,
    input  wire logic [7:0]  leg_tags_i,
    input  wire logic [5:0]  leg_vexc_i,
    input  wire logic        leg_tagrd_i,
    input  wire logic [7:0]  leg_zero_i,
    input  wire logic [7:0]  leg_spec_i,
    output logic      [15:0] leg_ftw_o,
    output logic             leg_ftw_valid_o,
    input  wire logic        leg_op_i,
    input  wire logic        leg_op_nat_i,
    input  wire logic        leg_op_sign_i,
    input  wire logic [16:0] leg_op_exp_i,
    input  wire logic [63:0] leg_op_sig_i,
    output logic             leg_res_valid_o,
    output logic             leg_inv_fault_o,
    output logic             leg_nat_prop_o,
    output logic             leg_delayed_exc_o,
    output logic             leg_res_sign_o,
    output logic      [16:0] leg_res_exp_o,
    output logic      [63:0] leg_res_sig_o,
    output logic      [63:0] legacy_fp_control_o
);

    logic [63:0] legacy_fp_control_reg;
    logic [63:0] legacy_fp_status_reg;
    logic [63:0] status_view;
    logic [63:0] write_resv;
    logic        resv_hit;
    logic        ctl_wr_ok;
    logic        sts_wr_ok;
    logic        error_summary;
    logic        es_written_reg;
    logic [15:0] ftw_next;
    logic        op_denorm;
    logic        op_range_bad;
    logic        op_fault;

    // Reserved-bit check on native writes, nothing else is verified
    assign write_resv = ar_wdata_i & ((ar_sel_i == LFCS_SEL_CTL) ? LFCS_CTL_RESV_MASK
                                                                  : LFCS_STS_RESV_MASK);
    assign resv_hit   = |write_resv;
    assign ctl_wr_ok  = ar_wr_i && !resv_hit && (ar_sel_i == LFCS_SEL_CTL);
    assign sts_wr_ok  = ar_wr_i && !resv_hit && (ar_sel_i == LFCS_SEL_STS);

    // Summary of flags whose mask bit is clear
    assign error_summary = |(legacy_fp_status_reg[LFCS_EXC_LSB +: LFCS_EXC_W]
                             & ~legacy_fp_control_reg[LFCS_MASK_LSB +: LFCS_EXC_W]);

    always_comb begin
        status_view = legacy_fp_status_reg & LFCS_STS_STORE_MASK;
        status_view[LFCS_ES_BIT] = error_summary;
        status_view[LFCS_BUSY_BIT] = error_summary;
    end

    // Control register; legacy-side units and the native read port read it, native status never enters
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            legacy_fp_control_reg <= LFCS_CTL_RESET;
        end else if (ctl_wr_ok) begin
            legacy_fp_control_reg <= ar_wdata_i & LFCS_CTL_STORE_MASK;
        end
    end

    // Status register; hardware sets of sticky flags win over a same-cycle write
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            legacy_fp_status_reg <= LFCS_STS_RESET;
        end else begin
            logic [63:0] nxt;
            nxt = legacy_fp_status_reg;
            if (sts_wr_ok) begin
                nxt = ar_wdata_i & LFCS_STS_STORE_MASK;
            end
            if (leg_upd_i) begin
                nxt[LFCS_EXC_LSB +: LFCS_EXC_W] = nxt[LFCS_EXC_LSB +: LFCS_EXC_W] | leg_exc_i;
                nxt[LFCS_SF_BIT] = nxt[LFCS_SF_BIT] | leg_sf_i;
                nxt[LFCS_C0_BIT] = leg_cc_i[0];
                nxt[LFCS_C1_BIT] = leg_cc_i[1];
                nxt[LFCS_C2_BIT] = leg_cc_i[2];
                nxt[LFCS_C3_BIT] = leg_cc_i[3];
                nxt[LFCS_TOP_LSB +: LFCS_TOP_W] = leg_top_i;
                nxt[LFCS_VEXC_LSB +: LFCS_EXC_W] = nxt[LFCS_VEXC_LSB +: LFCS_EXC_W] | leg_vexc_i;
                for (int i = 0; i < LFCS_NREG; i++) begin
                    nxt[LFCS_TAG_LSB + 2 * i] = leg_tags_i[i];
                end
            end
            legacy_fp_status_reg <= nxt;
        end
    end

    // A written-one summary forces a delayed exception on the next legacy op
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            es_written_reg <= 1'b0;
        end else if (sts_wr_ok && ar_wdata_i[LFCS_ES_BIT]) begin
            es_written_reg <= 1'b1;
        end else if (leg_op_i) begin
            es_written_reg <= 1'b0;
        end
    end

    // Native read port
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ar_rdata_o      <= 64'h0000_0000_0000_0000;
            ar_rvalid_o     <= 1'b0;
            ar_resv_fault_o <= 1'b0;
        end else begin
            ar_rvalid_o     <= ar_rd_i;
            ar_resv_fault_o <= ar_wr_i && resv_hit;
            if (ar_rd_i) begin
                ar_rdata_o <= (ar_sel_i == LFCS_SEL_CTL) ? legacy_fp_control_reg : status_view;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            legacy_fp_control_o <= LFCS_CTL_RESET;
        end else begin
            legacy_fp_control_o <= legacy_fp_control_reg;
        end
    end

    // Full tag word: stored empty tag, else classify from the register contents
    genvar g;
    generate
        for (g = 0; g < LFCS_NREG; g++) begin : g_tag
            assign ftw_next[2 * g +: 2] =
                legacy_fp_status_reg[LFCS_TAG_LSB + 2 * g] ? LFCS_TAG_EMPTY   :
                leg_spec_i[g]                              ? LFCS_TAG_SPECIAL :
                leg_zero_i[g]                              ? LFCS_TAG_ZERO    :
                                                             LFCS_TAG_VALID;
        end
    endgenerate

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            leg_ftw_o       <= 16'hFFFF;
            leg_ftw_valid_o <= 1'b0;
        end else begin
            leg_ftw_valid_o <= leg_tagrd_i;
            if (leg_tagrd_i) begin
                leg_ftw_o <= ftw_next;
            end
        end
    end

    // Operand checks at the boundary into the legacy unit
    assign op_denorm = ((leg_op_exp_i == SGL_DEN_EXP) || (leg_op_exp_i == DBL_DEN_EXP))
                       && !leg_op_sig_i[63] && (leg_op_sig_i != 64'h0000_0000_0000_0000);
    // Out-of-range wide exponents fault rather than round or convert
    assign op_range_bad = (leg_op_exp_i != LFCS_EXP_ZERO) && (leg_op_exp_i != LFCS_EXP_MAX)
                          && ((leg_op_exp_i < LFCS_EXP_LO) || (leg_op_exp_i > LFCS_EXP_HI));
    assign op_fault = leg_op_nat_i ? NAT_FAULTS : (op_denorm || op_range_bad);

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            leg_res_valid_o   <= 1'b0;
            leg_inv_fault_o   <= 1'b0;
            leg_nat_prop_o    <= 1'b0;
            leg_delayed_exc_o <= 1'b0;
            leg_res_sign_o    <= 1'b0;
            leg_res_exp_o     <= 17'h00000;
            leg_res_sig_o     <= 64'h0000_0000_0000_0000;
        end else begin
            leg_res_valid_o   <= leg_op_i;
            leg_inv_fault_o   <= leg_op_i && op_fault;
            leg_nat_prop_o    <= leg_op_i && leg_op_nat_i && !NAT_FAULTS;
            leg_delayed_exc_o <= leg_op_i && (error_summary || es_written_reg);
            if (leg_op_i) begin
                if (leg_op_nat_i) begin
                    // Carried NaT also shows as a signalling NaN value
                    leg_res_sign_o <= 1'b0;
                    leg_res_exp_o  <= LFCS_EXP_MAX;
                    leg_res_sig_o  <= LFCS_SNAN_SIG;
                end else begin
                    leg_res_sign_o <= leg_op_sign_i;
                    leg_res_exp_o  <= leg_op_exp_i;
                    leg_res_sig_o  <= leg_op_sig_i;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ==== verification/lfcs_regs_monitor.sv ====
// Port-level assertions for the legacy fp control/status register bank
`default_nettype none
module lfcs_regs_monitor
    import lfcs_pkg::*;
#(
    parameter logic [16:0] SGL_DEN_EXP = 17'h00001
) (
    input wire logic        clk_sys_i,
    input wire logic        resetn_i,
    input wire logic        ar_wr_i,
    input wire logic        ar_sel_i,
    input wire logic [63:0] ar_wdata_i,
    input wire logic [63:0] ar_rdata_o,
    input wire logic        ar_rvalid_o,
    input wire logic        ar_resv_fault_o,
    input wire logic        leg_tagrd_i,
    input wire logic [7:0]  leg_spec_i,
    input wire logic [15:0] leg_ftw_o,
    input wire logic        leg_ftw_valid_o,
    input wire logic        leg_op_i,
    input wire logic        leg_op_nat_i,
    input wire logic [16:0] leg_op_exp_i,
    input wire logic [63:0] leg_op_sig_i,
    input wire logic        leg_inv_fault_o,
    input wire logic        leg_nat_prop_o,
    input wire logic [63:0] legacy_fp_control_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    busy_mirror_a: assert property (ar_rvalid_o && $past(ar_sel_i)
        |-> ar_rdata_o[15] == ar_rdata_o[7]) else $error("busy differs from error summary");
    ignored_zero_a: assert property (ar_rvalid_o && $past(ar_sel_i)
        |-> (ar_rdata_o & 64'h0000_FF80_AAAA_0000) == 64'h0) else $error("ignored status bits not zero");
    resv_fault_a: assert property (ar_resv_fault_o ==
        $past(ar_wr_i && (|(ar_wdata_i & (ar_sel_i ? LFCS_STS_RESV_MASK : LFCS_CTL_RESV_MASK)))))
        else $error("reserved fault mismatch");
    // Control copy lags one cycle, so skip reads near a write
    es_summary_a: assert property (ar_rvalid_o && $past(ar_sel_i) && !$past(ar_wr_i) && !$past(ar_wr_i, 2)
        |-> ar_rdata_o[7] == |(ar_rdata_o[5:0] & ~legacy_fp_control_o[5:0])) else $error("error summary wrong");
    nat_guard_a: assert property (leg_op_i && leg_op_nat_i |=> leg_nat_prop_o != leg_inv_fault_o)
        else $error("not-a-thing used silently");
    denorm_fault_a: assert property (leg_op_i && !leg_op_nat_i && leg_op_exp_i == SGL_DEN_EXP && !leg_op_sig_i[63]
        && leg_op_sig_i != 64'h0 |=> leg_inv_fault_o) else $error("denormal not faulted");
    tag_class_a: assert property (leg_tagrd_i && leg_spec_i[1] |=> leg_ftw_valid_o && leg_ftw_o[3])
        else $error("tag class missing");
    ctl_copy_a: assert property (ar_wr_i && !ar_sel_i && !(|(ar_wdata_i & LFCS_CTL_RESV_MASK))
        |=> ##1 legacy_fp_control_o == ($past(ar_wdata_i, 2) & LFCS_CTL_STORE_MASK)) else $error("control copy wrong");
endmodule
bind lfcs_regs lfcs_regs_monitor #(.SGL_DEN_EXP(SGL_DEN_EXP)) u_mon (.*);
`default_nettype wire

// ==== verification/test_lfcs_regs.sv ====
// Directed bench for the legacy fp control/status register bank
`default_nettype none
module test_lfcs_regs import lfcs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_i = 0, resetn_i = 0, ar_wr_i = 0, ar_rd_i = 0, ar_sel_i = 0, leg_upd_i = 0, leg_sf_i = 0;
    logic        leg_tagrd_i = 0, leg_op_i = 0, leg_op_nat_i = 0, leg_op_sign_i = 0;
    logic [63:0] ar_wdata_i = 0, leg_op_sig_i = 0, ar_rdata_o, legacy_fp_control_o, leg_res_sig_o;
    logic [5:0]  leg_exc_i = 0, leg_vexc_i = 0;
    logic [3:0]  leg_cc_i = 0;
    logic [2:0]  leg_top_i = 0;
    logic [7:0]  leg_tags_i = 0, leg_zero_i = 0, leg_spec_i = 0;
    logic [16:0] leg_op_exp_i = 0, leg_res_exp_o;
    logic [15:0] leg_ftw_o;
    logic        ar_rvalid_o, ar_resv_fault_o, leg_ftw_valid_o, leg_res_valid_o, leg_inv_fault_o;
    logic        leg_nat_prop_o, leg_delayed_exc_o, leg_res_sign_o;
    int          fail_count = 0, total_checks = 0;
    lfcs_regs dut (.*);
    always #10 clk_sys_i = ~clk_sys_i;
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Drops every strobe after its taking edge, then steps off the edge
    task automatic step();
        @(posedge clk_sys_i);
        ar_wr_i <= 1'b0;
        ar_rd_i <= 1'b0;
        leg_upd_i <= 1'b0;
        leg_tagrd_i <= 1'b0;
        leg_op_i <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic s, input logic [63:0] d, input logic f);
        @(posedge clk_sys_i);
        ar_wr_i <= 1'b1;
        ar_sel_i <= s;
        ar_wdata_i <= d;
        step();
        chk("resv_fault", {63'h0, f}, {63'h0, ar_resv_fault_o});
    endtask
    task automatic rd(input logic s, input logic [63:0] e);
        @(posedge clk_sys_i);
        ar_rd_i <= 1'b1;
        ar_sel_i <= s;
        step();
        chk("rvalid", 64'h1, {63'h0, ar_rvalid_o});
        chk(s ? "status" : "control", e, ar_rdata_o);
    endtask
    task automatic op(input logic t, input logic [16:0] x, input logic [63:0] g, input logic f, p, d);
        @(posedge clk_sys_i);
        leg_op_i <= 1'b1;
        leg_op_nat_i <= t;
        leg_op_sign_i <= !t;
        leg_op_exp_i <= x;
        leg_op_sig_i <= g;
        step();
        chk("op_flags", {60'h0, 1'b1, f, p, d},
            {60'h0, leg_res_valid_o, leg_inv_fault_o, leg_nat_prop_o, leg_delayed_exc_o});
        if (!f) begin
            chk("op_exp", {46'h0, !t, t ? LFCS_EXP_MAX : x}, {46'h0, leg_res_sign_o, leg_res_exp_o});
            chk("op_sig", t ? LFCS_SNAN_SIG : g, leg_res_sig_o);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        fail_count++;
        final_report();
    end
    initial begin
        repeat (5) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        #1;
        chk("ftw_reset", 64'hFFFF, {48'h0, leg_ftw_o});
        rd(0, 64'h0);
        rd(1, 64'h0);
        wr(0, 64'h0000_FFBF_0000_1FFF, 0);
        rd(0, LFCS_CTL_STORE_MASK);
        wr(0, 64'h8000_0000_0000_0000, 1);
        wr(1, 64'h0000_0040_0000_0000, 1);
        rd(0, LFCS_CTL_STORE_MASK);
        wr(1, 64'h0000_FFBF_FFFF_FFFF, 0);
        rd(1, 64'h0000_003F_5555_7F7F);
        wr(0, 64'h0, 0);
        rd(1, 64'h0000_003F_5555_FFFF);
        wr(1, 64'h0, 0);
        @(posedge clk_sys_i);
        leg_upd_i <= 1'b1;
        {leg_exc_i, leg_sf_i, leg_cc_i, leg_top_i, leg_tags_i, leg_vexc_i} <= {6'h01, 1'b1, 4'hA, 3'h5, 8'h81, 6'h20};
        step();
        rd(1, 64'h0000_0020_4001_EAC1);
        @(posedge clk_sys_i);
        leg_tagrd_i <= 1'b1;
        {leg_zero_i, leg_spec_i} <= {8'h0A, 8'h06};
        step();
        chk("ftw", 64'h1_C06B, {47'h0, leg_ftw_valid_o, leg_ftw_o});
        wr(1, 64'h0, 0);
        op(1, 17'h0FFFF, 64'h8000_0000_0000_0000, 0, 1, 1);
        op(0, 17'h00001, 64'h4000_0000_0000_0000, 1, 0, 0);
        op(0, 17'h00002, 64'h0000_0000_0000_0001, 1, 0, 0);
        op(0, 17'h0C000, 64'h8000_0000_0000_0000, 0, 0, 0);
        op(0, 17'h13FFF, 64'h8000_0000_0000_0000, 1, 0, 0);
        op(0, 17'h0BFFF, 64'h8000_0000_0000_0000, 1, 0, 0);
        wr(1, 64'h80, 0);
        rd(1, 64'h0);
        op(0, 17'h0FFFF, 64'hC000_0000_0000_0000, 0, 0, 1);
        final_report();
    end
endmodule
`default_nettype wire
